// ==== inc/cca_pkg.sv ====
/*
 * Constants shared by the counter array and its capture/compare modules.
 * Assumes a single system clock domain and an 8-bit special function register port.
 */
package cca_pkg;

   // ----------------------------------------------------------------------
   // Sizes and timebase figures
   // ----------------------------------------------------------------------
   localparam int         NMOD       = 5;
   localparam logic [3:0] DIV12_LAST = 4'hB;  // Prescaler counts 0..11.
   localparam logic [1:0] DIV4_LAST  = 2'h3;
   localparam logic [2:0] OSC_LAST   = 3'h7;  // Eight oscillator ticks.

   // ----------------------------------------------------------------------
   // Register addresses on the special function register port
   // ----------------------------------------------------------------------
   localparam logic [7:0] A_CTRL  = 8'hD8;
   localparam logic [7:0] A_AMODE = 8'hD9;
   localparam logic [7:0] A_MODE0 = 8'hDA;
   localparam logic [7:0] A_CPL0  = 8'hE9;
   localparam logic [7:0] A_CPH0  = 8'hF0;
   localparam logic [7:0] A_CNTL  = 8'hF9;
   localparam logic [7:0] A_CNTH  = 8'hFA;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int B_WIDE = 7;
   localparam int B_ECOM = 6;
   localparam int B_CAPP = 5;
   localparam int B_CAPN = 4;
   localparam int B_MAT  = 3;
   localparam int B_TOG  = 2;
   localparam int B_PWM  = 1;
   localparam int B_ECCF = 0;
   localparam int B_CF   = 7;
   localparam int B_CR   = 6;
   localparam int B_ECF  = 0;
   localparam int B_CPS  = 1;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0]  MODE_RST = 8'h00;
   localparam logic [15:0] CP_RST   = 16'h0000;
   localparam logic [3:0]  AMODE_RST = 4'h0;

   typedef enum logic [2:0] {
      TB_DIV12 = 3'h0,
      TB_DIV4  = 3'h1,
      TB_T0    = 3'h2,
      TB_ECI   = 3'h3,
      TB_SYS   = 3'h4,
      TB_OSC   = 3'h5
   } timebase_t;

endpackage : cca_pkg

// ==== rtl/cc_channel.sv ====
/*
 * One capture/compare module: mode register, 16-bit compare pair and pin logic.
 * Assumes the counter, its change strobe and a filtered pin level from the array.
 */
`timescale 1ns/100ps
module cc_channel (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        mode_wr,
   input  wire logic        cpl_wr,
   input  wire logic        cph_wr,
   input  wire logic [7:0]  wdata,
   input  wire logic [15:0] cnt,
   input  wire logic        cnt_new,
   input  wire logic        pin_lvl,
   output logic [7:0]       mode_q,
   output logic [15:0]      cp_q,
   output logic             event_o,
   output logic             pin_q,
   output logic             pin_oe_n
);
   import cca_pkg::*;

   logic [7:0]  mode_d;
   logic [15:0] cp_d;
   logic        pin_d;
   logic        lvl_q;
   logic        cap_m, tmr_m, hso_m, frq_m, pwm_m, ecom;
   logic        m16, m8, wrap8, wrap16, cap_hit;

   // ----------------------------------------------------------------------
   // Mode decode and comparators
   // ----------------------------------------------------------------------
   always_comb begin
      ecom    = mode_q[B_ECOM];
      cap_m   = mode_q[3:1] == 3'h0;
      tmr_m   = mode_q[3:1] == 3'h4 && mode_q[5:4] == 2'h0;
      hso_m   = mode_q[3:1] == 3'h6 && mode_q[5:4] == 2'h0;
      frq_m   = mode_q[B_TOG] && mode_q[B_PWM] && mode_q[5:4] == 2'h0;
      pwm_m   = mode_q[B_PWM] && !mode_q[B_TOG] && mode_q[5:4] == 2'h0;
      m16     = cnt_new && cnt == cp_q;
      m8      = cnt_new && cnt[7:0] == cp_q[7:0];
      wrap8   = cnt_new && cnt[7:0] == 8'h00;
      wrap16  = cnt_new && cnt == 16'h0000;
      cap_hit = cap_m && ((mode_q[B_CAPP] && pin_lvl && !lvl_q) ||
                          (mode_q[B_CAPN] && !pin_lvl && lvl_q));
   end

   // Next mode, compare pair, pin level and event.
   always_comb begin
      mode_d  = mode_q;
      cp_d    = cp_q;
      pin_d   = pin_q;
      event_o = 1'b0;
      if (cap_hit) begin
         cp_d    = cnt;
         event_o = 1'b1;
      end
      if (tmr_m && ecom && mode_q[B_MAT] && m16) begin
         event_o = 1'b1;
      end
      if (hso_m && ecom && mode_q[B_MAT] && m16) begin
         pin_d   = !pin_q;
         event_o = 1'b1;
      end
      if (frq_m && ecom) begin
         if (m8) begin
            pin_d      = !pin_q;
            cp_d[7:0]  = cp_q[7:0] + cp_q[15:8];
         end
         if (mode_q[B_MAT] && m16) begin
            event_o = 1'b1;
         end
      end
      if (pwm_m) begin
         if (!ecom) begin
            pin_d = 1'b0;
         end else if (!mode_q[B_WIDE]) begin
            if (wrap8) begin
               pin_d     = 1'b0;
               cp_d[7:0] = cp_q[15:8];
            end
            if (m8 && !wrap8) begin
               pin_d = 1'b1;
            end else if (wrap8 && cp_q[15:8] == 8'h00) begin
               pin_d = 1'b1;
            end
            event_o = mode_q[B_MAT] && m8;
         end else begin
            if (wrap16) begin
               pin_d = 1'b0;
            end
            if (m16) begin
               pin_d = 1'b1;
            end
            event_o = mode_q[B_MAT] && m16;
         end
      end
      if (mode_wr) begin
         mode_d = wdata;
      end
      if (cpl_wr) begin
         cp_d[7:0]      = wdata;
         mode_d[B_ECOM] = 1'b0;
      end
      if (cph_wr) begin
         cp_d[15:8]     = wdata;
         mode_d[B_ECOM] = 1'b1;
      end
      pin_oe_n = !(hso_m || frq_m || pwm_m);
   end

   // Registers of the module.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= MODE_RST;
         cp_q   <= CP_RST;
         pin_q  <= 1'b0;
         lvl_q  <= 1'b0;
      end else begin
         mode_q <= mode_d;
         cp_q   <= cp_d;
         pin_q  <= pin_d;
         lvl_q  <= pin_lvl;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence cap_seq;
      cap_hit && !cpl_wr && !cph_wr;
   endsequence

   low_write_a: assert property (cpl_wr && !cph_wr |=> !mode_q[B_ECOM])
      else $error("low byte write left comparator enabled");
   high_write_a: assert property (cph_wr |=> mode_q[B_ECOM])
      else $error("high byte write did not enable comparator");
   capture_load_a: assert property (cap_seq |-> event_o ##1 cp_q == $past(cnt))
      else $error("capture did not load counter");
   timer_match_a: assert property (tmr_m && ecom && mode_q[B_MAT] && m16 |-> event_o)
      else $error("timer match did not raise event");
   hso_toggle_a: assert property (hso_m && ecom && mode_q[B_MAT] && m16
                                  |=> pin_q != $past(pin_q))
      else $error("high speed output did not toggle");
   freq_add_a: assert property (frq_m && ecom && m8 && !cpl_wr
                                |=> cp_q[7:0] == 8'($past(cp_q[7:0]) + $past(cp_q[15:8])))
      else $error("frequency offset not added");
   pwm_off_a: assert property (pwm_m && !ecom && !cph_wr && !mode_wr |=> !pin_q)
      else $error("disabled pwm output not low");
endmodule : cc_channel

// ==== rtl/counter_array.sv ====
/*
 * Counter array: shared 16-bit counter, timebase, event flags, interrupt tree and
 * five capture/compare modules on a byte-wide special function register port.
 * Assumes all inputs are synchronous to clk and the pin buffer is resolved outside.
 */
`timescale 1ns/100ps

// Notes on behaviour
// - Six event flags: counter overflow plus one per capture/compare module.
// - Flags set on their trigger regardless of enables; overflow interrupt needs its enable.
// - Interrupt reaches the processor only with global and array enables both set.
// - Mode bit 0 lets a module's set flag raise the array interrupt.
// - Mode bits 3..1 zero select capture; bits 5 and 4 pick rising, falling, both.
// - Bit 1 with bits 2, 4, 5 clear is PWM; bit 7 picks 8 or 16 bit.
// - Comparator disabled: output modes do not toggle, PWM outputs constant zero.
// - In PWM modes with match enabled every comparator match sets the flag.
// - Capture copies the counter into the module pair and sets the flag.
// - Module flags are not cleared by servicing; software clears them.
// - With both capture edges enabled the pin level stays readable on a port.
// - Software timer mode sets the flag when counter equals the module pair.
// - Low byte write clears comparator enable; high byte write sets it.
// - High speed output toggles the pin and sets the flag on each match.
// - Frequency output: low byte match toggles pin and adds high to low byte.
// - High byte is counter clocks per half period; zero means 256.
// - Frequency output with match bit sets the flag on full 16-bit equality.
// - 8-bit PWM: pin high on low byte match, low on low byte overflow.
// - 8-bit PWM reloads the low byte from the high byte on low byte wrap.
// - 8-bit PWM with match bit sets the flag on every rising edge match.
// - Overflow flag set on 0xFFFF to 0x0000 and never cleared by hardware.
// - Three-bit timebase select picks the counter increment source.
// - 16-bit PWM: pin high on 16-bit match, low on counter overflow.
module counter_array #(
   parameter int NCH = cca_pkg::NMOD
) (
   input  wire logic           clk,
   input  wire logic           rstn,
   input  wire logic [7:0]     sfr_addr,
   input  wire logic [7:0]     sfr_wdata,
   input  wire logic           sfr_wr,
   input  wire logic           sfr_rd,
   output logic [7:0]          sfr_rdata,
   input  wire logic           global_irq_enable,
   input  wire logic           array_irq_enable,
   input  wire logic           timer0_ovf,
   input  wire logic           external_count_input,
   input  wire logic           ext_osc_tick,
   input  wire logic [NCH-1:0] module_io_pin_in,
   output logic [NCH-1:0]      module_io_pin_out,
   output logic [NCH-1:0]      module_io_pin_oe_n,
   output logic [NCH-1:0]      pin_level,
   output logic                irq
);
   import cca_pkg::*;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [3:0]      div_q, div_d;
   logic [1:0]      eci_q, eci_d;
   logic [2:0]      osc_q, osc_d;
   logic            tick;
   logic            run_tick;
   logic [15:0]     cnt_q, cnt_d;
   logic            cnt_new_q, cnt_new_d;
   logic            cf_q, cf_d, cf_set;
   logic            cr_q, cr_d;
   logic [NCH-1:0]  ccf_q, ccf_d;
   logic [3:0]      amode_q, amode_d;
   logic [NCH-1:0]  s1_q, s2_q, lvl_q, lvl_d;
   logic [7:0]      rd_mux;
   logic [7:0]      rdata_d;
   logic            ctrl_wr;
   logic [NCH-1:0]  ev;
   logic [NCH-1:0]  eccf;
   logic [7:0]      mode_r [NCH];
   logic [15:0]     cp_r [NCH];
   timebase_t       tb;

   // ----------------------------------------------------------------------
   // Timebase selection
   // ----------------------------------------------------------------------
   // Prescaler, count input edge detector and oscillator divider.
   always_comb begin
      tb    = timebase_t'(amode_q[B_CPS +: 3]);
      div_d = (div_q == DIV12_LAST) ? 4'h0 : 4'(div_q + 4'h1);
      eci_d = {eci_q[0], external_count_input};
      osc_d = ext_osc_tick ? 3'(osc_q + 3'h1) : osc_q;
      case (tb)
         TB_DIV12: tick = div_q == DIV12_LAST;
         TB_DIV4:  tick = div_q[1:0] == DIV4_LAST;
         TB_T0:    tick = timer0_ovf;
         TB_ECI:   tick = eci_q[1] && !eci_q[0];
         TB_SYS:   tick = 1'b1;
         TB_OSC:   tick = ext_osc_tick && osc_q == OSC_LAST;
         default:  tick = 1'b0;
      endcase
      run_tick = cr_q && tick;
   end

   // Timebase registers.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= 4'h0;
         eci_q <= 2'h0;
         osc_q <= 3'h0;
      end else begin
         div_q <= div_d;
         eci_q <= eci_d;
         osc_q <= osc_d;
      end
   end

   // ----------------------------------------------------------------------
   // Counter, flags and mode register of the array
   // ----------------------------------------------------------------------
   // Software writes to the counter bytes override the step in that cycle.
   always_comb begin
      ctrl_wr   = sfr_wr && sfr_addr == A_CTRL;
      cnt_d     = run_tick ? 16'(cnt_q + 16'h0001) : cnt_q;
      cnt_new_d = run_tick;
      if (sfr_wr && sfr_addr == A_CNTL) begin
         cnt_d[7:0] = sfr_wdata;
      end
      if (sfr_wr && sfr_addr == A_CNTH) begin
         cnt_d[15:8] = sfr_wdata;
      end
      cf_set = run_tick && cnt_q == 16'hFFFF;
      // A hardware set in the same cycle as a software clear wins.
      cf_d  = cf_set || (ctrl_wr ? sfr_wdata[B_CF] : cf_q);
      ccf_d = ev | (ctrl_wr ? sfr_wdata[NCH-1:0] : ccf_q);
      cr_d  = ctrl_wr ? sfr_wdata[B_CR] : cr_q;
      amode_d = (sfr_wr && sfr_addr == A_AMODE) ? sfr_wdata[3:0] : amode_q;
   end

   // Counter and flag registers.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q     <= 16'h0000;
         cnt_new_q <= 1'b0;
         cf_q      <= 1'b0;
         ccf_q     <= '0;
         cr_q      <= 1'b0;
         amode_q   <= AMODE_RST;
      end else begin
         cnt_q     <= cnt_d;
         cnt_new_q <= cnt_new_d;
         cf_q      <= cf_d;
         ccf_q     <= ccf_d;
         cr_q      <= cr_d;
         amode_q   <= amode_d;
      end
   end

   // ----------------------------------------------------------------------
   // Pin input qualification
   // ----------------------------------------------------------------------
   // A new level is accepted only after two equal samples in a row.
   always_comb begin
      lvl_d = (s1_q & s2_q) | (lvl_q & (s1_q | s2_q));
   end

   // Pin sample registers.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q  <= '0;
         s2_q  <= '0;
         lvl_q <= '0;
      end else begin
         s1_q  <= module_io_pin_in;
         s2_q  <= s1_q;
         lvl_q <= lvl_d;
      end
   end

   assign pin_level = lvl_q;

   // ----------------------------------------------------------------------
   // Capture/compare modules
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < NCH; i++) begin : g_mod
      cc_channel u_ch (
         .clk      (clk),
         .rstn     (rstn),
         .mode_wr  (sfr_wr && sfr_addr == 8'(A_MODE0 + i)),
         .cpl_wr   (sfr_wr && sfr_addr == 8'(A_CPL0 + i)),
         .cph_wr   (sfr_wr && sfr_addr == 8'(A_CPH0 + i)),
         .wdata    (sfr_wdata),
         .cnt      (cnt_q),
         .cnt_new  (cnt_new_q),
         .pin_lvl  (lvl_q[i]),
         .mode_q   (mode_r[i]),
         .cp_q     (cp_r[i]),
         .event_o  (ev[i]),
         .pin_q    (module_io_pin_out[i]),
         .pin_oe_n (module_io_pin_oe_n[i])
      );
      assign eccf[i] = mode_r[i][B_ECCF];
   end

   // ----------------------------------------------------------------------
   // Interrupt tree
   // ----------------------------------------------------------------------
   // Flags set regardless of enables; only the request is gated.
   assign irq = global_irq_enable && array_irq_enable &&
                ((cf_q && amode_q[B_ECF]) || |(ccf_q & eccf));

   // ----------------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------------
   // Read data is held in a register and changes only on a read strobe.
   always_comb begin
      rd_mux = 8'h00;
      if (sfr_addr == A_CTRL) begin
         rd_mux = {cf_q, cr_q, 1'b0, 5'(ccf_q)};
      end else if (sfr_addr == A_AMODE) begin
         rd_mux = {4'h0, amode_q};
      end else if (sfr_addr == A_CNTL) begin
         rd_mux = cnt_q[7:0];
      end else if (sfr_addr == A_CNTH) begin
         rd_mux = cnt_q[15:8];
      end
      for (int k = 0; k < NCH; k++) begin
         if (sfr_addr == 8'(A_MODE0 + k)) begin
            rd_mux = mode_r[k];
         end
         if (sfr_addr == 8'(A_CPL0 + k)) begin
            rd_mux = cp_r[k][7:0];
         end
         if (sfr_addr == 8'(A_CPH0 + k)) begin
            rd_mux = cp_r[k][15:8];
         end
      end
      rdata_d = sfr_rd ? rd_mux : sfr_rdata;
   end

   // Read data register.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sfr_rdata <= 8'h00;
      end else begin
         sfr_rdata <= rdata_d;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence wrap_seq;
      run_tick && cnt_q == 16'hFFFF && !(sfr_wr && sfr_addr == A_CNTL);
   endsequence

   overflow_set_a: assert property (wrap_seq |=> cf_q && cnt_q[7:0] == 8'h00)
      else $error("counter wrap did not set overflow flag");
   set_wins_a: assert property (cf_set && ctrl_wr && !sfr_wdata[B_CF] |=> cf_q)
      else $error("flag clear beat a hardware set");
   flag_event_a: assert property (ev[0] |=> ccf_q[0])
      else $error("module event did not set its flag");
   irq_gate_a: assert property (irq |-> global_irq_enable && array_irq_enable)
      else $error("interrupt without both enables");
   ovf_irq_a: assert property (cf_q && amode_q[B_ECF] && global_irq_enable
                               && array_irq_enable |-> irq)
      else $error("overflow interrupt missing");
   mod_irq_a: assert property (|(ccf_q & eccf) && global_irq_enable
                               && array_irq_enable |-> irq)
      else $error("module interrupt missing");
   count_step_a: assert property (run_tick && !(sfr_wr && (sfr_addr == A_CNTL
                                  || sfr_addr == A_CNTH))
                                  |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
      else $error("counter did not step");
   pin_filter_a: assert property (s1_q[0] == s2_q[0] |=> lvl_q[0] == $past(s2_q[0]))
      else $error("stable pin level not accepted");
endmodule : counter_array

// ==== testbench/pin_source.sv ====
/*
 * Model of the external signal source on the module pins.
 * Assumes the bench calls its tasks just after a falling clock edge.
 */
`timescale 1ns/100ps
module pin_source (
   input  wire logic       clk,
   output logic      [4:0] pins
);
   // --------------------------------------------------------
   // Pin drivers
   // --------------------------------------------------------
   // All pins start low.
   initial begin
      pins = 5'h00;
   end
   // Holds a new level for n clocks, never fewer than two.
   task automatic level(input int i, input logic v, input int n);
      pins[i] = v;
      repeat ((n < 2) ? 2 : n) @(negedge clk);
   endtask : level
   // One-clock pulse, too short to be seen; used on purpose.
   task automatic glitch(input int i);
      pins[i] = ~pins[i];
      @(negedge clk);
      pins[i] = ~pins[i];
      @(negedge clk);
   endtask : glitch
endmodule : pin_source

// ==== testbench/counter_array_capture_compare_tb_top.sv ====
/*
 * Self-checking bench for the counter array.
 * Assumes the pin source model and the register map of cca_pkg.
 */
`timescale 1ns/100ps
module counter_array_capture_compare_tb_top;
   import cca_pkg::*;
   logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ge = 1'b0, ae = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [4:0] pin_in, pin_out, oe_n, lvl;
   logic [1:0] ph = 2'h0;
   logic       irq;
   int         error_cnt = 0, cmp_count = 0, cycles = 0;

   // --------------------------------------------------------
   // Clock, design and pin source
   // --------------------------------------------------------
   // Clock of 10 ns period.
   always #5 clk = ~clk;
   // Phase counter that makes a timer 0 pulse and a count input fall every fourth clock.
   always @(negedge clk) ph <= 2'(ph + 2'h1);
   counter_array dut_u (.clk(clk), .rstn(rstn), .sfr_addr(addr), .sfr_wdata(wdata),
      .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .global_irq_enable(ge),
      .array_irq_enable(ae), .timer0_ovf(ph == 2'h0), .external_count_input(ph[1]),
      .ext_osc_tick(1'b1), .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
      .module_io_pin_oe_n(oe_n), .pin_level(lvl), .irq(irq));
   pin_source ps_u (.clk(clk), .pins(pin_in));

   // --------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------
   // Counts and reports one comparison.
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", s, e, g);
      end
   endtask : chk
   // One register write; a spare clock keeps strobes apart.
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      addr  = a;
      wdata = d;
      wr    = 1'b1;
      @(negedge clk);
      wr    = 1'b0;
      @(negedge clk);
   endtask : wreg
   // One register read.
   task automatic rget(input logic [7:0] a, output logic [7:0] d);
      addr = a;
      rd   = 1'b1;
      @(negedge clk);
      rd   = 1'b0;
      d    = rdata;
      @(negedge clk);
   endtask : rget
   // Reads a register and compares it.
   task automatic rreg(input logic [7:0] a, input logic [7:0] e, input string s);
      logic [7:0] d;
      rget(a, d);
      chk(s, 16'(e), 16'(d));
   endtask : rreg
   // Counts clocks until a module pin output changes.
   task automatic gap(input int i, output int n);
      logic s;
      s = pin_out[i];
      n = 0;
      while (pin_out[i] === s && n < 700) begin
         @(negedge clk);
         n++;
      end
   endtask : gap
   // Prints the counts and the verdict, then stops.
   task automatic wrap_up;
      $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   // --------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------
   // Reset state of flags, mode and pin enables.
   task automatic t_reset;
      rreg(A_CTRL, 8'h00, "flags at reset");
      rreg(A_MODE0, 8'h00, "mode at reset");
      chk("oe_n at reset", 16'h001F, 16'(oe_n));
   endtask : t_reset
   // Edge capture, filter, interrupt tree and flag holding.
   task automatic t_capture;
      wreg(A_CNTL, 8'h34);
      wreg(A_CNTH, 8'h12);
      wreg(A_MODE0, 8'h21);
      ps_u.glitch(0);
      rreg(A_CTRL, 8'h00, "short pulse");
      ps_u.level(0, 1'b1, 5);
      rreg(A_CPL0, 8'h34, "capture low");
      rreg(A_CPH0, 8'h12, "capture high");
      rreg(A_CTRL, 8'h01, "capture flag");
      ge = 1'b1;
      ae = 1'b1;
      @(negedge clk);
      chk("irq enabled", 16'h1, 16'(irq));
      ge = 1'b0;
      @(negedge clk);
      chk("irq global off", 16'h0, 16'(irq));
      ge = 1'b1;
      repeat (10) @(negedge clk);
      rreg(A_CTRL, 8'h01, "flag held");
      wreg(A_CTRL, 8'h00);
      chk("irq cleared", 16'h0, 16'(irq));
      wreg(A_CNTL, 8'h55);
      ps_u.level(0, 1'b0, 5);
      rreg(A_CPL0, 8'h34, "fall ignored");
      wreg(A_MODE0, 8'h31);
      ps_u.level(0, 1'b1, 5);
      rreg(A_CPL0, 8'h55, "any edge");
      chk("pin level", 16'h1, 16'(lvl[0]));
   endtask : t_capture
   // Compare byte pairing, software timer and overflow.
   task automatic t_timer;
      wreg(A_MODE0 + 8'h01, 8'h48);
      wreg(A_CPL0 + 8'h01, 8'h05);
      rreg(A_MODE0 + 8'h01, 8'h08, "low clears");
      wreg(A_CPH0 + 8'h01, 8'h00);
      rreg(A_MODE0 + 8'h01, 8'h48, "high sets");
      wreg(A_CNTL, 8'hF0);
      wreg(A_CNTH, 8'hFF);
      wreg(A_AMODE, 8'h08);
      wreg(A_CTRL, 8'h40);
      repeat (30) @(negedge clk);
      rreg(A_CTRL, 8'hC2, "wrap and match");
      chk("irq no enables", 16'h0, 16'(irq));
      wreg(A_AMODE, 8'h09);
      chk("irq overflow", 16'h1, 16'(irq));
   endtask : t_timer
   // Counter steps in 120 clocks for timebase codes 0 to 6, reserved code 6 included.
   task automatic t_timebase;
      logic [7:0] a, b;
      int         exp[7] = '{10, 30, 30, 30, 120, 15, 0};
      for (int k = 0; k < 7; k++) begin
         wreg(A_AMODE, 8'(k << 1));
         rget(A_CNTL, a);
         repeat (118) @(negedge clk);
         rget(A_CNTL, b);
         chk("steps", 16'(exp[k]), 16'(8'(b - a)));
      end
   endtask : t_timebase
   // 8-bit PWM high time after reload, then comparator off.
   task automatic t_pwm8;
      int n;
      wreg(A_CPL0 + 8'h02, 8'h10);
      wreg(A_CPH0 + 8'h02, 8'hC0);
      wreg(A_MODE0 + 8'h02, 8'h42);
      chk("pwm oe_n", 16'h0, 16'(oe_n[2]));
      if (pin_out[2] === 1'b1) begin
         gap(2, n);
      end
      repeat (4) gap(2, n);
      chk("pwm high", 16'd64, 16'(n));
      wreg(A_CPL0 + 8'h02, 8'h00);
      n = 0;
      repeat (300) begin
         @(negedge clk);
         if (pin_out[2] !== 1'b0) n++;
      end
      chk("pwm off", 16'h0, 16'(n));
   endtask : t_pwm8
   // Frequency output half period, with zero meaning 256.
   task automatic t_freq;
      int n;
      logic [7:0] hv[2] = '{8'h10, 8'h00};
      int         ev[2] = '{16, 256};
      for (int k = 0; k < 2; k++) begin
         wreg(A_CPL0 + 8'h03, 8'h00);
         wreg(A_CPH0 + 8'h03, hv[k]);
         wreg(A_MODE0 + 8'h03, 8'h46);
         gap(3, n);
         gap(3, n);
         chk("half period", 16'(ev[k]), 16'(n));
      end
   endtask : t_freq
   // High speed toggle, then both edges of 16-bit PWM, on module 4.
   task automatic t_hso16;
      wreg(A_CTRL, 8'h40);
      wreg(A_CPL0 + 8'h04, 8'h00);
      wreg(A_CPH0 + 8'h04, 8'h80);
      wreg(A_MODE0 + 8'h04, 8'h4C);
      chk("hso oe_n", 16'h0, 16'(oe_n[4]));
      wreg(A_CNTL, 8'hF0);
      wreg(A_CNTH, 8'h7F);
      repeat (20) @(negedge clk);
      chk("hso toggle", 16'h1, 16'(pin_out[4]));
      rreg(A_CTRL, 8'h50, "hso flag");
      wreg(A_MODE0 + 8'h04, 8'hCA);
      wreg(A_CNTL, 8'hF0);
      wreg(A_CNTH, 8'hFF);
      repeat (20) @(negedge clk);
      chk("pwm16 low", 16'h0, 16'(pin_out[4]));
      wreg(A_CTRL, 8'h40);
      wreg(A_CNTL, 8'hF0);
      wreg(A_CNTH, 8'h7F);
      repeat (20) @(negedge clk);
      chk("pwm16 high", 16'h1, 16'(pin_out[4]));
      rreg(A_CTRL, 8'h50, "pwm16 flag");
   endtask : t_hso16

   // --------------------------------------------------------
   // Sequence and watchdog
   // --------------------------------------------------------
   // Stops a hung run.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end
   // Main sequence.
   initial begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      t_reset();
      t_capture();
      t_timer();
      t_timebase();
      wreg(A_AMODE, 8'h08);
      t_pwm8();
      t_freq();
      t_hso16();
      wrap_up();
   end
endmodule : counter_array_capture_compare_tb_top
